/* include/amu_map.vh */
// Constants for the aligned memory access unit.
// Assumes a 20 MHz clock with two clock cycles per instruction cycle.
`ifndef AMU_MAP_VH
`define AMU_MAP_VH

// Clock and instruction cycle timing
`define AMU_CLK_NS 50
`define AMU_ICYC_NS 100
`define AMU_HALF_CYC (`AMU_ICYC_NS / 2 / `AMU_CLK_NS)
`define AMU_ICYC_CLKS (2 * `AMU_HALF_CYC)

// Widths
`define AMU_PADDR_W 18
`define AMU_MADDR_W 20
`define AMU_DATA_W 16
`define AMU_IDXSEL_W 7
`define AMU_PAGE_W 6

// Memory and program address field positions
`define AMU_PAGE_LSB 14
`define AMU_PAGE_MSB 19
`define AMU_WORD_LSB 0
`define AMU_WORD_MSB 11
`define AMU_PA_WORD_LSB 1
`define AMU_PA_WORD_MSB 12
`define AMU_PA_PAGE_LSB 13
`define AMU_PA_PAGE_MSB 17

// Opcode fields: bit 0 write, bit 1 indexed, bits 3:2 kind
`define AMU_OP_WR 0
`define AMU_OP_IX 1
`define AMU_KIND_NONE 2'h0
`define AMU_KIND_FIRST 2'h1
`define AMU_KIND_SECOND 2'h2
`define AMU_KIND_PAIR 2'h3
`define AMU_OP_NOP 4'h0
`define AMU_OP_PAUSE 4'h1

// Slot positions in clock cycles after the instruction is taken
`define AMU_SLOT0_CYC 4'h0
`define AMU_SLOT1_CYC 4'h2
`define AMU_SLOT1H_CYC 4'h3
`define AMU_SLOT5_CYC 4'hA
`define AMU_SLOT5H_CYC 4'hB
`define AMU_SYNC_CYC 4'h2
`define AMU_LAST_CYC 4'hD

// Least spacing between accesses to one page, in clock cycles
`define AMU_PAGE_GAP_CYC 4

`endif

/* design/amu_align.v */
// Address alignment network: program address to data memory address.
// Purely combinational; caller registers the result.
`timescale 1ns/1ps
`include "amu_map.vh"

module amu_align (
	aligned,
	paddr,
	maddr
);
	input wire aligned;
	input wire [`AMU_PADDR_W-1:0] paddr;
	output reg [`AMU_MADDR_W-1:0] maddr;

	integer k;

	always @* begin
		maddr = {`AMU_MADDR_W{1'b0}};
		if (aligned) begin
			for (k = 0; k <= `AMU_WORD_MSB; k = k + 1) begin
				maddr[`AMU_WORD_LSB + k] = paddr[`AMU_PA_WORD_LSB + k];
			end
			maddr[`AMU_PAGE_LSB] = paddr[0];
			for (k = 0; k < 5; k = k + 1) begin
				maddr[`AMU_PAGE_LSB + 1 + k] = paddr[`AMU_PA_PAGE_LSB + k];
			end
		end else begin
			maddr = {2'h0, paddr};
		end
	end
endmodule

/* design/amu_page_guard.v */
// Per-page spacing guard for data memory pages.
// Flags a touch of a page whose previous touch is too recent.
`timescale 1ns/1ps
`include "amu_map.vh"

module amu_page_guard #(
	parameter PAGES = 64,
	parameter GAP = `AMU_PAGE_GAP_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire touch,
	input wire [`AMU_PAGE_W-1:0] page,
	output wire too_soon
);
	wire [PAGES-1:0] busy;

	genvar g;
	generate
		for (g = 0; g < PAGES; g = g + 1) begin : pg
			reg [3:0] cnt_r;
			always @(posedge clk) begin
				if (!rst_n) begin
					cnt_r <= 4'h0;
				end else if (touch && page == g) begin
					cnt_r <= GAP[3:0] - 4'h1;
				end else if (cnt_r != 4'h0) begin
					cnt_r <= cnt_r - 4'h1;
				end
			end
			assign busy[g] = (cnt_r != 4'h0);
		end
	endgenerate

	assign too_soon = touch & busy[page];
endmodule

/* design/amu_top.v */
// Aligned memory access unit of the memory address processor.
// Assumes the index file answers idx_rd_data in the cycle idx_rd_en is
// high, and that external bus activity arrives asynchronously on pins.
`timescale 1ns/1ps
`include "amu_map.vh"

module amu_top #(
	parameter PAGE_GAP = `AMU_PAGE_GAP_CYC
) (
	clk,
	rst_n,
	instr_valid,
	instr_op,
	instr_aligned,
	instr_addr,
	instr_idx_sel,
	instr_wdata0,
	instr_wdata1,
	instr_pause,
	instr_pause_cnt,
	en_overrange,
	en_underrange,
	idx_rd_data,
	ext_abus_busy,
	ext_dbus_busy,
	dbus_in,
	idx_rd_en,
	idx_rd_sel,
	abus_out,
	abus_oe,
	dbus_out,
	dbus_oe,
	rd_data0,
	rd_data1,
	rd_valid,
	busy,
	done,
	reject,
	err_flags,
	aggregate_error_line
);
	input wire clk;
	input wire rst_n;
	input wire instr_valid;
	input wire [3:0] instr_op;
	input wire instr_aligned;
	input wire [`AMU_PADDR_W-1:0] instr_addr;
	input wire [`AMU_IDXSEL_W-1:0] instr_idx_sel;
	input wire [`AMU_DATA_W-1:0] instr_wdata0;
	input wire [`AMU_DATA_W-1:0] instr_wdata1;
	input wire instr_pause;
	input wire [2:0] instr_pause_cnt;
	input wire en_overrange;
	input wire en_underrange;
	input wire [`AMU_PADDR_W-1:0] idx_rd_data;
	input wire ext_abus_busy;
	input wire ext_dbus_busy;
	input wire [`AMU_DATA_W-1:0] dbus_in;
	output reg idx_rd_en;
	output reg [`AMU_IDXSEL_W-1:0] idx_rd_sel;
	output reg [`AMU_MADDR_W-1:0] abus_out;
	output reg abus_oe;
	output reg [`AMU_DATA_W-1:0] dbus_out;
	output reg dbus_oe;
	output reg [`AMU_DATA_W-1:0] rd_data0;
	output reg [`AMU_DATA_W-1:0] rd_data1;
	output reg rd_valid;
	output reg busy;
	output reg done;
	output reg reject;
	output reg [3:0] err_flags;
	output reg aggregate_error_line;

	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_NOP = 2'h2;
	localparam ST_PAUSE = 2'h3;

	localparam ERR_TIME = 0;
	localparam ERR_BUS = 1;
	localparam ERR_OVER = 2;
	localparam ERR_UNDER = 3;

	reg [1:0] state_r;
	reg [3:0] cyc_r;
	reg [4:0] pcnt_r;
	reg [3:0] op_r;
	reg aligned_r;
	reg [`AMU_PADDR_W-1:0] addr_r;
	reg [`AMU_DATA_W-1:0] wd0_r;
	reg [`AMU_DATA_W-1:0] wd1_r;
	reg pause_r;
	reg [2:0] pause_cnt_r;
	reg [`AMU_PADDR_W-1:0] ea0_r;
	reg [`AMU_PADDR_W-1:0] ea1_r;

	// Pin synchronisers
	reg ab_busy_s1_r;
	reg ab_busy_s2_r;
	reg db_busy_s1_r;
	reg db_busy_s2_r;
	reg [`AMU_DATA_W-1:0] dbus_s1_r;
	reg [`AMU_DATA_W-1:0] dbus_s2_r;

	wire is_wr = op_r[`AMU_OP_WR];
	wire is_ix = op_r[`AMU_OP_IX];
	wire [1:0] kind = op_r[3:2];
	wire use_first = (kind == `AMU_KIND_FIRST) || (kind == `AMU_KIND_PAIR);
	wire use_second = (kind == `AMU_KIND_SECOND) ||
		(kind == `AMU_KIND_PAIR);
	wire is_pair = (kind == `AMU_KIND_PAIR);

	// Effective address with signed index, 20 bits to expose range faults
	wire [19:0] base_ext = {2'h0, addr_r};
	wire [19:0] idx_ext = is_ix ?
		{{2{idx_rd_data[`AMU_PADDR_W-1]}}, idx_rd_data} : 20'h00000;
	wire [19:0] sum0 = base_ext + idx_ext;
	wire [19:0] sum1 = sum0 + 20'h00001;
	wire over0 = ~sum0[19] & sum0[18];
	wire under0 = sum0[19];
	wire over1 = ~sum1[19] & sum1[18];
	wire under1 = sum1[19];
	wire rng_over = over0 | (is_pair & over1);
	wire rng_under = under0 | (is_pair & under1);

	// Mapped addresses for the two slots
	wire [`AMU_MADDR_W-1:0] map0;
	wire [`AMU_MADDR_W-1:0] map1;

	amu_align u_align0 (
		.aligned(aligned_r),
		.paddr(ea0_r),
		.maddr(map0)
	);

	amu_align u_align1 (
		.aligned(aligned_r),
		.paddr(ea1_r),
		.maddr(map1)
	);

	// Page touches happen as each address is placed on the bus
	wire touch0 = (state_r == ST_RUN) && use_first &&
		(cyc_r == `AMU_SLOT1_CYC - 4'h1);
	wire touch1 = (state_r == ST_RUN) && use_second &&
		(cyc_r == `AMU_SLOT1H_CYC - 4'h1);
	wire touch = touch0 | touch1;
	wire [`AMU_PAGE_W-1:0] touch_page = touch0 ?
		map0[`AMU_PAGE_MSB:`AMU_PAGE_LSB] :
		map1[`AMU_PAGE_MSB:`AMU_PAGE_LSB];
	wire too_soon;

	amu_page_guard #(
		.PAGES(64),
		.GAP(PAGE_GAP)
	) u_guard (
		.clk(clk),
		.rst_n(rst_n),
		.touch(touch),
		.page(touch_page),
		.too_soon(too_soon)
	);

	// bus conflict windows after the sync delay
	wire chk_a1 = (cyc_r == `AMU_SLOT1_CYC + `AMU_SYNC_CYC);
	wire chk_a2 = (cyc_r == `AMU_SLOT1H_CYC + `AMU_SYNC_CYC);
	wire chk_r1 = (cyc_r == `AMU_SLOT5_CYC + `AMU_SYNC_CYC);
	wire chk_r2 = (cyc_r == `AMU_SLOT5H_CYC + `AMU_SYNC_CYC);
	wire conflict_a = (chk_a1 & use_first | chk_a2 & use_second) &
		ab_busy_s2_r;
	wire conflict_dw = is_wr & (chk_a1 & use_first | chk_a2 & use_second) &
		db_busy_s2_r;
	wire conflict_dr = ~is_wr & (chk_r1 & use_first | chk_r2 & use_second) &
		db_busy_s2_r;
	wire conflict = (state_r == ST_RUN) &
		(conflict_a | conflict_dw | conflict_dr);

	// Range checks resolve in the slot 0 cycle
	wire rng_chk = (state_r == ST_RUN) && (cyc_r == `AMU_SLOT0_CYC);
	wire rep_over = rng_chk & rng_over & en_overrange;
	wire rep_under = rng_chk & is_ix & rng_under & en_underrange;

	wire [3:0] err_now = {rep_under, rep_over, conflict, too_soon};

	wire take = (state_r == ST_IDLE) && instr_valid;
	wire take_nop = (instr_op == `AMU_OP_NOP);
	wire take_pause = (instr_op == `AMU_OP_PAUSE);
	wire take_access = (instr_op[3:2] != `AMU_KIND_NONE);

	always @(posedge clk) begin
		if (!rst_n) begin
			ab_busy_s1_r <= 1'b0;
			ab_busy_s2_r <= 1'b0;
			db_busy_s1_r <= 1'b0;
			db_busy_s2_r <= 1'b0;
			dbus_s1_r <= {`AMU_DATA_W{1'b0}};
			dbus_s2_r <= {`AMU_DATA_W{1'b0}};
		end else begin
			ab_busy_s1_r <= ext_abus_busy;
			ab_busy_s2_r <= ab_busy_s1_r;
			db_busy_s1_r <= ext_dbus_busy;
			db_busy_s2_r <= db_busy_s1_r;
			dbus_s1_r <= dbus_in;
			dbus_s2_r <= dbus_s1_r;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cyc_r <= 4'h0;
			pcnt_r <= 5'h00;
			op_r <= 4'h0;
			aligned_r <= 1'b0;
			addr_r <= {`AMU_PADDR_W{1'b0}};
			wd0_r <= {`AMU_DATA_W{1'b0}};
			wd1_r <= {`AMU_DATA_W{1'b0}};
			pause_r <= 1'b0;
			pause_cnt_r <= 3'h0;
			ea0_r <= {`AMU_PADDR_W{1'b0}};
			ea1_r <= {`AMU_PADDR_W{1'b0}};
			idx_rd_en <= 1'b0;
			idx_rd_sel <= {`AMU_IDXSEL_W{1'b0}};
			abus_out <= {`AMU_MADDR_W{1'b0}};
			abus_oe <= 1'b0;
			dbus_out <= {`AMU_DATA_W{1'b0}};
			dbus_oe <= 1'b0;
			rd_data0 <= {`AMU_DATA_W{1'b0}};
			rd_data1 <= {`AMU_DATA_W{1'b0}};
			rd_valid <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			reject <= 1'b0;
			err_flags <= 4'h0;
			aggregate_error_line <= 1'b0;
		end else begin
			done <= 1'b0;
			rd_valid <= 1'b0;
			reject <= 1'b0;
			idx_rd_en <= 1'b0;
			aggregate_error_line <= |err_now;
			err_flags <= err_flags | err_now;
			case (state_r)
			ST_IDLE: begin
				if (take) begin
					// no-op refused when paired with pause
					if (take_nop && instr_pause) begin
						reject <= 1'b1;
					end else begin
						op_r <= instr_op;
						aligned_r <= instr_aligned;
						addr_r <= instr_addr;
						wd0_r <= instr_wdata0;
						wd1_r <= instr_wdata1;
						pause_r <= instr_pause | take_pause;
						pause_cnt_r <= instr_pause_cnt;
						err_flags <= 4'h0;
						busy <= 1'b1;
						cyc_r <= 4'h0;
						if (take_access) begin
							state_r <= ST_RUN;
							idx_rd_en <= instr_op[`AMU_OP_IX];
							idx_rd_sel <= instr_idx_sel;
						end else if (take_pause) begin
							state_r <= ST_PAUSE;
							pcnt_r <= {1'b0, instr_pause_cnt, 1'b0};
						end else begin
							state_r <= ST_NOP;
						end
					end
				end
			end
			ST_NOP: begin
				cyc_r <= cyc_r + 4'h1;
				if (cyc_r == `AMU_ICYC_CLKS - 1) begin
					state_r <= ST_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
			ST_RUN: begin
				cyc_r <= cyc_r + 4'h1;
				if (cyc_r == `AMU_SLOT0_CYC) begin
					// second word is address plus one, or the address itself for a second-slot-only access
					if (kind == `AMU_KIND_SECOND) begin
						ea1_r <= sum0[`AMU_PADDR_W-1:0];
					end else begin
						ea1_r <= sum1[`AMU_PADDR_W-1:0];
					end
					ea0_r <= sum0[`AMU_PADDR_W-1:0];
				end
				if (cyc_r == `AMU_SLOT1_CYC - 4'h1) begin
					// in aligned mode, address and successor in neighbour pages
					abus_out <= map0;
					abus_oe <= use_first;
					dbus_out <= wd0_r;
					dbus_oe <= is_wr & use_first;
				end
				if (cyc_r == `AMU_SLOT1H_CYC - 4'h1) begin
					abus_out <= map1;
					abus_oe <= use_second;
					dbus_out <= is_pair ? wd1_r : wd0_r;
					dbus_oe <= is_wr & use_second;
				end
				if (cyc_r == `AMU_SLOT1H_CYC) begin
					abus_oe <= 1'b0;
					dbus_oe <= 1'b0;
				end
				if (chk_r1 && use_first && !is_wr) begin
					rd_data0 <= dbus_s2_r;
				end
				if (chk_r2 && use_second && !is_wr) begin
					if (is_pair) begin
						rd_data1 <= dbus_s2_r;
					end else begin
						rd_data0 <= dbus_s2_r;
					end
				end
				if (cyc_r == `AMU_LAST_CYC) begin
					rd_valid <= ~is_wr;
					if (pause_r && pause_cnt_r != 3'h0) begin
						state_r <= ST_PAUSE;
						pcnt_r <= {1'b0, pause_cnt_r, 1'b0};
					end else begin
						state_r <= ST_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
			ST_PAUSE: begin
				if (pcnt_r <= 5'h01) begin
					state_r <= ST_IDLE;
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					pcnt_r <= pcnt_r - 5'h01;
				end
			end
			default: begin
				state_r <= ST_IDLE;
				busy <= 1'b0;
			end
			endcase
		end
	end
endmodule

/* sim/amu_check_sva.sv */
// Checker for the aligned access unit, bound onto amu_top.
// Assumes the header constants and a synchronous active-low reset.
`timescale 1ns/1ps
`include "amu_map.vh"
module amu_check (
	input wire clk,
	input wire rst_n,
	input wire instr_valid,
	input wire [3:0] instr_op,
	input wire instr_aligned,
	input wire instr_pause,
	input wire [17:0] instr_addr,
	input wire [6:0] instr_idx_sel,
	input wire [15:0] instr_wdata0,
	input wire busy,
	input wire done,
	input wire reject,
	input wire [19:0] abus_out,
	input wire abus_oe,
	input wire [15:0] dbus_out,
	input wire dbus_oe,
	input wire idx_rd_en,
	input wire [6:0] idx_rd_sel,
	input wire [3:0] err_flags,
	input wire aggregate_error_line
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	reg [17:0] a_r;
	reg [3:0] op_r;
	reg [15:0] w_r;
	reg [6:0] s_r;
	wire take = instr_valid && !busy;
	wire acc = take && instr_op[3:2] != 2'h0 && !instr_pause;
	wire nop = take && instr_op == `AMU_OP_NOP;
	wire pl = take && instr_aligned && !instr_op[1];
	function [19:0] amap(input [17:0] x);
		amap = {x[17:13], x[0], 2'h0, x[12:1]};
	endfunction
	always @(posedge clk) begin
		if (take) begin
			a_r <= instr_addr;
			op_r <= instr_op;
			w_r <= instr_wdata0;
			s_r <= instr_idx_sel;
		end
	end
	a_done_access: assert property (acc |-> ##15 done)
		else $error("access done not on time");
	a_nop_span: assert property (nop && !instr_pause |->
		##1 (!abus_oe && !aggregate_error_line) [*2] ##1 done)
		else $error("no-op span wrong");
	a_nop_refuse: assert property (nop && instr_pause |->
		##1 reject)
		else $error("combined no-op not refused");
	a_first_addr: assert property (pl && instr_op[2] |->
		##3 abus_oe && abus_out == amap(a_r))
		else $error("first slot address wrong");
	a_second_addr: assert property (pl && instr_op[3] |->
		##4 abus_oe && abus_out == amap(a_r + op_r[2]))
		else $error("second slot address wrong");
	a_one_slot: assert property (pl && instr_op[3:2] == 2'h1 |->
		##4 !abus_oe)
		else $error("single access used two slots");
	a_write_data: assert property (take && instr_op == 4'h5 |->
		##3 dbus_oe && dbus_out == w_r ##1 !dbus_oe)
		else $error("write data slot wrong");
	a_idx_read: assert property (take && instr_op[1] &&
		instr_op[3:2] != 2'h0 |-> ##1 idx_rd_en && idx_rd_sel == s_r)
		else $error("index not read in slot zero");
	a_line_cause: assert property (aggregate_error_line |->
		err_flags != 4'h0)
		else $error("error line without cause");
	cover property (acc && instr_op[3:2] == `AMU_KIND_PAIR);
	cover property (nop && instr_pause);
	cover property (aggregate_error_line);
	cover property (take && instr_op == `AMU_OP_PAUSE);
endmodule
bind amu_top amu_check chk (.clk(clk), .rst_n(rst_n),
	.instr_valid(instr_valid), .instr_op(instr_op),
	.instr_aligned(instr_aligned), .instr_pause(instr_pause),
	.instr_addr(instr_addr), .instr_idx_sel(instr_idx_sel),
	.instr_wdata0(instr_wdata0), .busy(busy), .done(done),
	.reject(reject), .abus_out(abus_out), .abus_oe(abus_oe),
	.dbus_out(dbus_out), .dbus_oe(dbus_oe), .idx_rd_en(idx_rd_en),
	.idx_rd_sel(idx_rd_sel), .err_flags(err_flags),
	.aggregate_error_line(aggregate_error_line));

/* sim/amu_mem_model.sv */
// Paged data memory on the shared buses.
// Assumes one address per slot cycle; data answers 7 cycles later.
`timescale 1ns/1ps
module amu_mem_model (
	input wire clk,
	input wire [19:0] abus_out,
	input wire abus_oe,
	input wire [15:0] dbus_out,
	input wire dbus_oe,
	output logic [15:0] dbus_in = 16'h0000
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] wq [$];
	int tq [$];
	int cnt = 0;
	always @(posedge clk) begin
		cnt++;
		if (abus_oe && dbus_oe)
			mem[abus_out] = dbus_out;
		else if (abus_oe) begin
			wq.push_back(mem.exists(abus_out) ? mem[abus_out] : ~abus_out[15:0]);
			tq.push_back(cnt + 7);
		end
		if (tq.size() > 0 && tq[0] == cnt) begin
			dbus_in <= wq.pop_front();
			void'(tq.pop_front());
		end else
			dbus_in <= ~dbus_in;
	end
endmodule

/* sim/test_aligned_memory_access_unit.sv */
// Self-checking bench for the aligned memory access unit.
// Assumes the memory model as far side and an index file of one value.
`timescale 1ns/1ps
`include "amu_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_aligned_memory_access_unit;
	reg clk = 0, rst_n = 0, iv = 0, al = 0, ps = 0, eo = 0, eu = 0;
	reg eab = 0, edb = 0;
	reg [3:0] op = 0;
	reg [2:0] pc = 0;
	reg [17:0] ad = 0, ix = 0;
	reg [15:0] w0 = 0, w1 = 0;
	wire [15:0] din, dout, r0, r1;
	wire [19:0] aout;
	wire [6:0] isel;
	wire [3:0] ef;
	wire ire, aoe, doe, rv, busy, done, rej, ael;
	int fails = 0, checked = 0, nb = 0, nv = 0;
	int unsigned sd = 18;
	reg [19:0] aq [$];
	reg [15:0] rm [reg [19:0]];
	bit seen;
	amu_top #(.PAGE_GAP(2)) uut (.clk(clk), .rst_n(rst_n),
		.instr_valid(iv), .instr_op(op), .instr_aligned(al),
		.instr_addr(ad), .instr_idx_sel(ad[6:0]), .instr_wdata0(w0),
		.instr_wdata1(w1), .instr_pause(ps), .instr_pause_cnt(pc),
		.en_overrange(eo), .en_underrange(eu), .idx_rd_data(ix),
		.ext_abus_busy(eab), .ext_dbus_busy(edb), .dbus_in(din),
		.idx_rd_en(ire), .idx_rd_sel(isel), .abus_out(aout),
		.abus_oe(aoe), .dbus_out(dout), .dbus_oe(doe), .rd_data0(r0),
		.rd_data1(r1), .rd_valid(rv), .busy(busy), .done(done),
		.reject(rej), .err_flags(ef), .aggregate_error_line(ael));
	amu_mem_model mem (.clk(clk), .abus_out(aout), .abus_oe(aoe),
		.dbus_out(dout), .dbus_oe(doe), .dbus_in(din));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (aoe)
			aq.push_back(aout);
		if (ael)
			seen = 1;
		if (busy)
			nb++;
		if (rv)
			nv++;
	end
	function int unsigned rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction
	function [19:0] mp(input a, input [17:0] x);
		mp = a ? {x[17:13], x[0], 2'h0, x[12:1]} : {2'h0, x};
	endfunction
	function [15:0] rd(input [19:0] m);
		rd = rm.exists(m) ? rm[m] : ~m[15:0];
	endfunction
	task summarize;
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Env bits: underrange enable, overrange enable, data busy, addr busy
	task run(input [3:0] o, input a, input [17:0] x, input [17:0] i,
		input p, input [2:0] c, input [3:0] env);
		int e, ii, n, ec;
		bit pr, acc;
		reg [19:0] m0, m1;
		reg [3:0] f, k;
		@(posedge clk);
		op <= o;
		al <= a;
		ad <= x;
		ix <= i;
		ps <= p;
		pc <= c;
		{eu, eo, edb, eab} <= env;
		iv <= 1;
		w0 <= 16'(rnd());
		w1 <= 16'(rnd());
		@(posedge clk);
		iv <= 0;
		aq = {};
		seen = 0;
		nb = 0;
		nv = 0;
		if (o == 4'h0 && p) begin
			@(posedge clk);
			`CHK("reject", 1'b1, rej)
			`CHK("reject_busy", 1'b0, busy)
			return;
		end
		acc = o[3:2] != 2'h0;
		ii = $signed(i);
		pr = o[3:2] == 2'h3;
		e = x + (o[1] ? ii : 0);
		m0 = mp(a, e[17:0]);
		m1 = mp(a, e[17:0] + 18'h1);
		f = {o[1] && e < 0, (pr ? e + 1 : e) > 262143, env[1] | env[0],
			pr && m0[19:14] == m1[19:14]};
		if (!acc)
			f = 4'h0;
		k = {env[3], env[2], 2'h3};
		ec = o == 4'h0 ? 3 : (!acc ? 1 + 2 * c : 15 + 2 * p * c);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!done && n < 60);
		@(negedge clk);
		`CHK("cycles", ec, n)
		`CHK("busy", ec - 1, nb)
		`CHK("line", |(f & k), seen)
		`CHK("err_flags", f & k, ef & k)
		`CHK("slots", acc ? 1 + pr : 0, aq.size())
		`CHK("rd_valid", acc && !o[0], nv)
		if (aq.size() > 0)
			`CHK("addr0", m0, aq[0])
		if (pr && aq.size() > 1)
			`CHK("addr1", m1, aq[1])
		if (acc && o[0]) begin
			rm[m0] = w0;
			if (pr)
				rm[m1] = w1;
		end else if (acc && !(env[1] | env[0])) begin
			`CHK("rd_data0", rd(m0), r0)
			if (pr)
				`CHK("rd_data1", rd(m1), r1)
		end
	endtask
	initial begin
		#100000;
		fails++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		for (int j = 0; j < 6; j++) begin
			reg [3:0] o;
			reg [17:0] x, i;
			o = 4'((j % 3 + 1) * 4 + (j / 3) * 2);
			x = 18'(rnd() % 32'h1F000);
			i = 18'(rnd() & 32'hFF);
			run(o | 4'h1, 1, x, i, 0, 0, 4'h0);
			run(o, 1, x, i, 0, 0, 4'h0);
		end
		run(4'hC, 0, 18'(rnd()), 0, 0, 0, 4'h0);
		run(4'h4, 1, 18'h00123, 0, 0, 0, 4'h1);
		run(4'h8, 1, 18'h00456, 0, 0, 0, 4'h2);
		run(4'hC, 1, 18'h3FFFF, 0, 0, 0, 4'h4);
		run(4'hC, 1, 18'h3FFFF, 0, 0, 0, 4'h0);
		run(4'h6, 1, 18'h00002, 18'h3FFFB, 0, 0, 4'h8);
		run(4'h0, 0, 0, 0, 0, 0, 4'h0);
		run(4'h1, 0, 0, 0, 0, 2, 4'h0);
		run(4'h0, 0, 0, 0, 1, 2, 4'h0);
		run(4'hA, 1, 18'(rnd()), 18'h3, 1, 3, 4'h0);
		summarize();
	end
endmodule
